// [logic/fabric_bridge_pkg.sv]
// Shared constants for the fabric interface bridge: map, fields, resets and encodings.
package fabric_bridge_pkg;

	// ==========================================================================
	// Register map of the Wishbone slave (byte addresses, one word each).
	// ==========================================================================
	localparam logic [3:0] CTRL_OFS      = 4'h0;
	localparam logic [3:0] REGION_OFS    = 4'h4;
	localparam logic [3:0] STATUS_OFS    = 4'h8;
	localparam logic [3:0] COUNT_OFS     = 4'hc;

	// ==========================================================================
	// Control register fields and reset value.
	// ==========================================================================
	localparam int CTRL_APB_BIT    = 0;
	localparam int CTRL_MASTER_BIT = 1;
	localparam int CTRL_SLAVE_BIT  = 2;
	localparam int CTRL_BYPASS_BIT = 3;
	localparam int CTRL_IDENT_BIT  = 4;
	localparam int CTRL_RATIO_LSB  = 5;
	localparam int CTRL_WIDTH      = 8;
	localparam logic [7:0] CTRL_RESET = 8'h06;

	// ==========================================================================
	// Fabric regions: six 256 MB windows picked out by the top address nibble.
	// ==========================================================================
	localparam int REGION_COUNT = 6;
	localparam logic [5:0] REGION_RESET = 6'h38;
	localparam logic [REGION_COUNT-1:0][3:0] REGION_NIBBLE = {4'hf, 4'h9, 4'h8, 4'h7, 4'h5, 4'h3};

	// ==========================================================================
	// Clock ratio selection: 0 gives 1:1 up to 5 giving 32:1.
	// ==========================================================================
	localparam logic [2:0] RATIO_MAX_SEL = 3'h5;

	// ==========================================================================
	// Outbound widths and bus encodings.
	// ==========================================================================
	localparam int OUT_ADDR_W = 20;
	localparam logic [1:0] TRANS_IDLE   = 2'h0;
	localparam logic [1:0] TRANS_NONSEQ = 2'h2;

	// Initiator identity codes on the outbound sideband.
	localparam logic [1:0] IDENT_CPU    = 2'h0;
	localparam logic [1:0] IDENT_FABRIC = 2'h1;
	localparam logic [1:0] IDENT_DMA    = 2'h2;
	localparam logic [1:0] IDENT_SYSCTL = 2'h3;

	// Inbound fabric masters that can share the inbound port.
	localparam int IN_MASTERS = 4;

endpackage : fabric_bridge_pkg

// [logic/ratio_divider.sv]
// Clock enable divider that produces the bridge clock tick from the processor clock.
`timescale 1ns/1ps
module ratio_divider
(
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	input  wire logic [2:0] ratioSel,
	output logic            tick
);

	typedef struct packed
	{
		logic [4:0] cnt;
		logic       tick;
	} div_state_t;

	div_state_t st_q;
	div_state_t st_d;
	logic [2:0] sel;
	logic [4:0] limit;

	// ==========================================================================
	// Divider.
	// ==========================================================================
	// Out of range selections clamp to the slowest ratio rather than stopping the bridge.
	always_comb
	begin
		sel   = (ratioSel > fabric_bridge_pkg::RATIO_MAX_SEL) ? fabric_bridge_pkg::RATIO_MAX_SEL
		                                                       : ratioSel;
		limit = 5'((6'h01 << sel) - 6'h01); // [R5]
		st_d  = st_q;
		if (st_q.cnt >= limit)
		begin
			st_d.cnt  = 5'h00;
			st_d.tick = 1'b1;
		end
		else
		begin
			st_d.cnt  = st_q.cnt + 5'h01;
			st_d.tick = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign tick = st_q.tick; // [R4]

	// A 1:1 ratio must tick on every cycle once running.
	property p_ratio_one;
		@(posedge core_clk) disable iff (!arst_n)
		(ratioSel == 3'h0) [*2] |-> tick;
	endproperty
	a_ratio_one: assert property (p_ratio_one) else $error("1:1 ratio missed a tick."); // [R5]

endmodule : ratio_divider

// [logic/outbound_master.sv]
// Outbound bus master that carries processor requests to a fabric AHB-Lite or APB slave.
`timescale 1ns/1ps
module outbound_master
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        tick,
	input  wire logic        isApb,
	input  wire logic        bypass,
	input  wire logic        identEn,
	input  wire logic        portEn,
	input  wire logic        regionHit,
	input  wire logic        reqValid,
	input  wire logic [31:0] reqAddr,
	input  wire logic        reqWrite,
	input  wire logic [31:0] reqWdata,
	input  wire logic [1:0]  reqSize,
	input  wire logic        reqLock,
	input  wire logic [1:0]  reqInit,
	output logic             rspValid,
	output logic [31:0]      rspRdata,
	output logic             rspErr,
	output logic             busy,
	output logic [19:0]      outAddr,
	output logic [31:0]      outWdata,
	output logic             outWrite,
	output logic [1:0]       outSize,
	output logic [1:0]       outTrans,
	output logic             outLock,
	output logic [1:0]       outIdent,
	output logic             outSel,
	output logic             outEnable,
	input  wire logic [31:0] outRdata,
	input  wire logic        outReady,
	input  wire logic        outErr
);

	typedef enum logic [2:0] {OB_IDLE, OB_ADDR, OB_DATA, OB_SAMPLE, OB_RESP} ob_fsm_t;

	typedef struct packed
	{
		ob_fsm_t     fsm;
		logic        rspValid;
		logic [31:0] rspRdata;
		logic        rspErr;
		logic [19:0] addr;
		logic [31:0] wdata;
		logic        write;
		logic [1:0]  size;
		logic [1:0]  trans;
		logic        lock;
		logic [1:0]  ident;
		logic        sel;
		logic        enable;
	} ob_state_t;

	ob_state_t st_q;
	ob_state_t st_d;

	// ==========================================================================
	// Transfer sequencer.
	// ==========================================================================
	// Pipelined mode parks the slave answer in a flop for one bridge cycle; bypass
	// hands it back at once, which saves that cycle but lengthens the timing path.
	always_comb
	begin
		st_d          = st_q;
		st_d.rspValid = 1'b0;
		case (st_q.fsm)
			OB_IDLE:
			begin
				if (reqValid && (!portEn || !regionHit))
				begin
					st_d.rspErr   = 1'b1; // [R12] [R16]
					st_d.rspRdata = 32'h0000_0000;
					st_d.rspValid = 1'b1;
					st_d.fsm      = OB_RESP;
				end
				else if (reqValid && tick)
				begin
					st_d.addr  = reqAddr[19:0]; // [R14]
					st_d.write = reqWrite;
					st_d.size  = reqSize;
					st_d.lock  = reqLock && !isApb;
					st_d.ident = identEn ? reqInit : fabric_bridge_pkg::IDENT_CPU; // [R9] [R10] [R11]
					if (isApb)
					begin
						st_d.sel   = 1'b1; // [R1]
						st_d.wdata = reqWdata;
					end
					else
						st_d.trans = fabric_bridge_pkg::TRANS_NONSEQ; // [R1]
					st_d.fsm = OB_ADDR;
				end
			end
			OB_ADDR:
			begin
				if (tick)
				begin
					if (isApb)
						st_d.enable = 1'b1;
					else
					begin
						st_d.trans = fabric_bridge_pkg::TRANS_IDLE;
						st_d.lock  = 1'b0;
						st_d.wdata = reqWdata;
					end
					st_d.fsm = OB_DATA;
				end
			end
			OB_DATA:
			begin
				// The slave stretches the transfer by holding ready low.
				if (tick && outReady) // [R13]
				begin
					st_d.sel      = 1'b0;
					st_d.enable   = 1'b0;
					st_d.rspRdata = st_q.write ? 32'h0000_0000 : outRdata;
					st_d.rspErr   = outErr; // [R15]
					if (bypass)
					begin
						st_d.rspValid = 1'b1; // [R6]
						st_d.fsm      = OB_RESP;
					end
					else
						st_d.fsm = OB_SAMPLE; // [R5]
				end
			end
			OB_SAMPLE:
			begin
				if (tick)
				begin
					st_d.rspValid = 1'b1;
					st_d.fsm      = OB_RESP;
				end
			end
			// One quiet cycle lets the requester drop its request before the next look.
			OB_RESP:
				st_d.fsm = OB_IDLE;
			default:
				st_d.fsm = OB_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			st_q <= '{fsm: OB_IDLE, default: '0};
		else
			st_q <= st_d;
	end

	assign rspValid  = st_q.rspValid;
	assign rspRdata  = st_q.rspRdata;
	assign rspErr    = st_q.rspErr;
	assign busy      = (st_q.fsm != OB_IDLE);
	assign outAddr   = st_q.addr;
	assign outWdata  = st_q.wdata;
	assign outWrite  = st_q.write;
	assign outSize   = st_q.size;
	assign outTrans  = st_q.trans;
	assign outLock   = st_q.lock;
	assign outIdent  = st_q.ident;
	assign outSel    = st_q.sel;
	assign outEnable = st_q.enable;

	// The sideband stands with the address phase and carries the requester code.
	property p_ident_timing;
		@(posedge core_clk) disable iff (!arst_n)
		$rose(outTrans[1]) |-> (outIdent == (identEn ? $past(reqInit) : 2'h0));
	endproperty
	a_ident_timing: assert property (p_ident_timing) else $error("Identity off address phase."); // [R10]

	// An APB access phase always follows a setup phase of exactly one bridge cycle.
	property p_apb_setup;
		@(posedge core_clk) disable iff (!arst_n)
		$rose(outEnable) |-> ($past(outSel) && !$past(outEnable) && outSel);
	endproperty
	a_apb_setup: assert property (p_apb_setup) else $error("APB enable without setup."); // [R1]

	// A refused request is answered with an error on the very next cycle.
	property p_refuse;
		@(posedge core_clk) disable iff (!arst_n)
		(!busy && reqValid && !portEn) |=> (rspValid && rspErr && !outSel && (outTrans == 2'h0));
	endproperty
	a_refuse: assert property (p_refuse) else $error("Absent port did not refuse."); // [R12]

	// Only address bits 19:0 reach the fabric.
	property p_addr_width;
		@(posedge core_clk) disable iff (!arst_n)
		$rose(outTrans[1]) |-> (outAddr == $past(reqAddr[19:0]));
	endproperty
	a_addr_width: assert property (p_addr_width) else $error("Outbound address mismatch."); // [R14]

endmodule : outbound_master

// [logic/fabric_interface_bridge.sv]
// Top of one fabric bridge instance: register slave, region decode, clocking, inbound port.
`timescale 1ns/1ps
// Overview of operation
// R1 - Software selects AHB-Lite or APB bridging toward the fabric per instance.
// R2 - Instance has an outbound master port and an inbound slave port.
// R3 - Inbound AHB-Lite port serves up to four fabric masters.
// R4 - Each instance steps on its own bridge clock enable, independent of others.
// R5 - Pipelined by default; bridge ratio 1, 2, 4, 8, 16 or 32 to one.
// R6 - Bypass drops the answer register, saving a bridge cycle per transfer.
// R7 - Bypass only takes effect with AHB-Lite, never with APB.
// R8 - Software must choose ratio 1:1 whenever it enables bypass.
// R9 - Optional two-bit sideband names the internal initiator of outbound transfers.
// R10 - Sideband changes with the address phase, like transfer type and lock.
// R11 - Codes: 00 processor, 01 fabric bridges, 10 DMA/Ethernet/USB, 11 system controller.
// R12 - Outbound and inbound ports each enabled separately; a disabled port stays silent.
// R13 - Fabric parties follow AHB-Lite or APB handshakes, stretching with ready.
// R14 - Outbound address to fabric slaves is a 20-bit byte address.
// R15 - Outbound slave signals error high at the end of a failed transfer.
// R16 - Six 256 MB regions, each owned by exactly one bridge instance.
module fabric_interface_bridge
#(
	parameter logic INSTANCE_SEL = 1'b0
)
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        reqValid,
	input  wire logic [31:0] reqAddr,
	input  wire logic        reqWrite,
	input  wire logic [31:0] reqWdata,
	input  wire logic [1:0]  reqSize,
	input  wire logic        reqLock,
	input  wire logic [1:0]  reqInit,
	output logic             rspValid,
	output logic [31:0]      rspRdata,
	output logic             rspErr,
	output logic [19:0]      outAddr,
	output logic [31:0]      outWdata,
	output logic             outWrite,
	output logic [1:0]       outSize,
	output logic [1:0]       outTrans,
	output logic             outLock,
	output logic [1:0]       outIdent,
	output logic             outSel,
	output logic             outEnable,
	input  wire logic [31:0] outRdata,
	input  wire logic        outReady,
	input  wire logic        outErr,
	input  wire logic        inSel,
	input  wire logic [1:0]  inTrans,
	input  wire logic [31:0] inAddr,
	input  wire logic        inWrite,
	input  wire logic [1:0]  inSize,
	input  wire logic        inLock,
	input  wire logic [1:0]  inMaster,
	input  wire logic [31:0] inWdata,
	output logic [31:0]      inRdata,
	output logic             inReady,
	output logic             inResp,
	output logic             sysReqValid,
	output logic [31:0]      sysAddr,
	output logic             sysWrite,
	output logic [31:0]      sysWdata,
	output logic [1:0]       sysSize,
	output logic             sysLock,
	output logic [1:0]       sysMaster,
	input  wire logic        sysRspValid,
	input  wire logic [31:0] sysRdata,
	input  wire logic        sysErr
);

	typedef enum logic [2:0] {IB_IDLE, IB_DATA, IB_FWD, IB_HOLD, IB_ERR} ib_fsm_t;

	typedef struct packed
	{
		logic [7:0]                                  ctrl;
		logic [5:0]                                  region;
		logic                                        ack;
		logic [31:0]                                 rdata;
		ib_fsm_t                                     ibFsm;
		logic [31:0]                                 inRdata;
		logic                                        inReady;
		logic                                        inResp;
		logic                                        sysReq;
		logic [31:0]                                 sysAddr;
		logic                                        sysWrite;
		logic [31:0]                                 sysWdata;
		logic [1:0]                                  sysSize;
		logic                                        sysLock;
		logic [1:0]                                  sysMaster;
		logic                                        sysErrHeld;
		logic [fabric_bridge_pkg::IN_MASTERS-1:0][7:0] inCount;
	} top_state_t;

	top_state_t st_q;
	top_state_t st_d;

	logic       isApb;
	logic       bypassEff;
	logic [2:0] ratioEff;
	logic       tick;
	logic       regionHit;
	logic       obBusy;
	logic       wbReq;
	logic [5:0] regionMatch;

	// ==========================================================================
	// Mode decode.
	// ==========================================================================
	// Bypass is honoured only on AHB-Lite at 1:1; any other mix falls back to
	// pipelined operation so a misconfigured ratio cannot break timing.
	assign isApb     = st_q.ctrl[fabric_bridge_pkg::CTRL_APB_BIT]; // [R1]
	assign bypassEff = st_q.ctrl[fabric_bridge_pkg::CTRL_BYPASS_BIT] && !isApb // [R7]
	                   && (st_q.ctrl[7:5] == 3'h0); // [R8]
	assign ratioEff  = st_q.ctrl[7:5]; // [R5]

	// ==========================================================================
	// Region decode: a request is ours only if its region belongs to this instance.
	// ==========================================================================
	generate
		for (genvar r = 0; r < fabric_bridge_pkg::REGION_COUNT; r++)
		begin : g_region
			assign regionMatch[r] = (reqAddr[31:28] == fabric_bridge_pkg::REGION_NIBBLE[r])
			                        && (st_q.region[r] == INSTANCE_SEL); // [R16]
		end
	endgenerate
	assign regionHit = |regionMatch;

	// ==========================================================================
	// Bridge clock enable and outbound master.
	// ==========================================================================
	ratio_divider u_div
	(
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.ratioSel (ratioEff),
		.tick     (tick)
	);

	outbound_master u_out
	(
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.tick      (tick),
		.isApb     (isApb),
		.bypass    (bypassEff),
		.identEn   (st_q.ctrl[fabric_bridge_pkg::CTRL_IDENT_BIT]),
		.portEn    (st_q.ctrl[fabric_bridge_pkg::CTRL_MASTER_BIT]),
		.regionHit (regionHit),
		.reqValid  (reqValid),
		.reqAddr   (reqAddr),
		.reqWrite  (reqWrite),
		.reqWdata  (reqWdata),
		.reqSize   (reqSize),
		.reqLock   (reqLock),
		.reqInit   (reqInit),
		.rspValid  (rspValid),
		.rspRdata  (rspRdata),
		.rspErr    (rspErr),
		.busy      (obBusy),
		.outAddr   (outAddr),
		.outWdata  (outWdata),
		.outWrite  (outWrite),
		.outSize   (outSize),
		.outTrans  (outTrans),
		.outLock   (outLock),
		.outIdent  (outIdent),
		.outSel    (outSel),
		.outEnable (outEnable),
		.outRdata  (outRdata),
		.outReady  (outReady),
		.outErr    (outErr)
	);

	assign wbReq = wb_cyc_i && wb_stb_i && !st_q.ack;

	// ==========================================================================
	// Register slave and inbound slave port.
	// ==========================================================================
	always_comb
	begin
		st_d     = st_q;
		st_d.ack = wbReq;
		// Writes honour byte enables; unmapped addresses acknowledge and read zero.
		if (wbReq && wb_we_i)
		begin
			if ((wb_adr_i == fabric_bridge_pkg::CTRL_OFS) && wb_sel_i[0])
				st_d.ctrl = wb_dat_i[7:0]; // [R1] [R5] [R6] [R9] [R12]
			if ((wb_adr_i == fabric_bridge_pkg::REGION_OFS) && wb_sel_i[0])
				st_d.region = wb_dat_i[5:0]; // [R16]
		end
		if (wbReq && !wb_we_i)
		begin
			case (wb_adr_i)
				fabric_bridge_pkg::CTRL_OFS:   st_d.rdata = {24'h000000, st_q.ctrl};
				fabric_bridge_pkg::REGION_OFS: st_d.rdata = {26'h0, st_q.region};
				fabric_bridge_pkg::STATUS_OFS:
					st_d.rdata = {25'h0, ratioEff, bypassEff,
					              (st_q.ibFsm != IB_IDLE), obBusy, tick};
				fabric_bridge_pkg::COUNT_OFS:  st_d.rdata = st_q.inCount;
				default:                       st_d.rdata = 32'h0000_0000;
			endcase
		end

		// Inbound port: steps only on bridge ticks toward the fabric side.
		case (st_q.ibFsm)
			IB_IDLE:
			begin
				if (tick)
				begin
					st_d.inResp  = 1'b0;
					st_d.inReady = 1'b1;
					if (st_q.ctrl[fabric_bridge_pkg::CTRL_SLAVE_BIT] && !isApb // [R12]
					    && inSel && inTrans[1] && st_q.inReady)
					begin
						st_d.sysAddr   = inAddr;
						st_d.sysWrite  = inWrite;
						st_d.sysSize   = inSize;
						st_d.sysLock   = inLock;
						st_d.sysMaster = inMaster; // [R3]
						st_d.inCount[inMaster] = st_q.inCount[inMaster] + 8'h01; // [R3]
						st_d.inReady   = 1'b0; // [R13]
						st_d.ibFsm     = IB_DATA;
					end
				end
			end
			IB_DATA:
			begin
				// Write data belongs to the data phase, one bridge cycle after the address.
				if (tick)
				begin
					st_d.sysWdata = inWdata;
					st_d.sysReq   = 1'b1; // [R2]
					st_d.ibFsm    = IB_FWD;
				end
			end
			IB_FWD:
			begin
				if (sysRspValid)
				begin
					st_d.sysReq     = 1'b0;
					st_d.inRdata    = st_q.sysWrite ? 32'h0000_0000 : sysRdata;
					st_d.sysErrHeld = sysErr;
					st_d.ibFsm      = IB_HOLD;
				end
			end
			IB_HOLD:
			begin
				if (tick)
				begin
					st_d.inResp  = st_q.sysErrHeld;
					st_d.inReady = !st_q.sysErrHeld;
					st_d.ibFsm   = st_q.sysErrHeld ? IB_ERR : IB_IDLE;
				end
			end
			// Second cycle of the two-cycle AHB-Lite error answer.
			IB_ERR:
			begin
				if (tick)
				begin
					st_d.inReady = 1'b1;
					st_d.ibFsm   = IB_IDLE;
				end
			end
			default:
				st_d.ibFsm = IB_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q         <= '{ibFsm: IB_IDLE, default: '0};
			st_q.ctrl    <= fabric_bridge_pkg::CTRL_RESET;
			st_q.region  <= fabric_bridge_pkg::REGION_RESET;
			st_q.inReady <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	assign wb_ack_o    = st_q.ack;
	assign wb_dat_o    = st_q.rdata;
	assign inRdata     = st_q.inRdata;
	assign inReady     = st_q.inReady;
	assign inResp      = st_q.inResp;
	assign sysReqValid = st_q.sysReq;
	assign sysAddr     = st_q.sysAddr;
	assign sysWrite    = st_q.sysWrite;
	assign sysWdata    = st_q.sysWdata;
	assign sysSize     = st_q.sysSize;
	assign sysLock     = st_q.sysLock;
	assign sysMaster   = st_q.sysMaster;

	// ==========================================================================
	// Checks.
	// ==========================================================================
	// Each accepted request gets one ack cycle.
	property p_wb_ack;
		@(posedge core_clk) disable iff (!arst_n)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("Wishbone ack not a single cycle.");

	// APB never runs with bypass in effect.
	property p_bypass_apb;
		@(posedge core_clk) disable iff (!arst_n)
		isApb |-> !bypassEff;
	endproperty
	a_bypass_apb: assert property (p_bypass_apb) else $error("Bypass active on APB."); // [R7]

	// A disabled inbound port forwards nothing.
	property p_inbound_off;
		@(posedge core_clk) disable iff (!arst_n)
		(!st_q.ctrl[2] && st_q.ibFsm == IB_IDLE) |=> !sysReqValid;
	endproperty
	a_inbound_off: assert property (p_inbound_off) else $error("Disabled inbound forwarded."); // [R12]

	// The error answer runs two phases in order.
	property p_in_err;
		@(posedge core_clk) disable iff (!arst_n)
		$rose(inResp) |-> !inReady ##[1:32] (inResp && inReady);
	endproperty
	a_in_err: assert property (p_in_err) else $error("Inbound error answer malformed."); // [R13]

	// Foreign regions never start a transfer.
	property p_region_excl;
		@(posedge core_clk) disable iff (!arst_n)
		(reqValid && !obBusy && !regionHit) |=> (!outSel
		 && !outTrans[1]);
	endproperty
	a_region_excl: assert property (p_region_excl) else $error("Foreign region accepted."); // [R16]

endmodule : fabric_interface_bridge

// [sim/fabric_slave_model.sv]
// Behavioural fabric slave on the outbound port.
`timescale 1ns/1ps
module fabric_slave_model
(
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic [19:0] outAddr,
	input  wire logic [1:0]  outTrans,
	input  wire logic        outSel,
	input  wire logic        outEnable,
	input  wire logic        slow,
	input  wire logic        failAll,
	input  wire logic        tick,
	output logic [31:0]      outRdata,
	output logic             outReady,
	output logic             outErr
);
	typedef struct packed {logic [1:0] hold; logic busy; logic [19:0] addr;} mdl_t;
	mdl_t s_q, s_d;
	logic newReq;
	// A new request reloads the wait count, so slow mode stretches each transfer.
	always_comb
	begin
		newReq = outTrans[1] | (outSel & ~outEnable);
		s_d = s_q;
		s_d.busy = newReq | (s_q.busy & ~(outReady & ~outSel));
		if (newReq)
		begin
			s_d.hold = slow ? 2'h3 : 2'h0;
			s_d.addr = outAddr;
		end
		else if (s_q.hold != 2'h0)
			s_d.hold = s_q.hold - 2'h1;
	end
	// The slave runs on bridge ticks only.
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			s_q <= '0;
		else if (tick)
			s_q <= s_d;
	// Outside a data phase the bus shows junk, except in the bridge cycle after an APB access, which still shows the word.
	assign outReady = (s_q.hold == 2'h0);
	assign outErr   = failAll & s_q.busy & outReady;
	assign outRdata = (s_q.busy & outReady) ? {12'ha5a, s_q.addr} : ~{12'ha5a, s_q.addr};
endmodule : fabric_slave_model

// [sim/fabric_interface_bridge_bench.sv]
// Self-checking bench for one bridge instance.
`timescale 1ns/1ps
module fabric_interface_bridge_bench;
	logic core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, reqValid, reqWrite, reqLock;
	logic rspValid, rspErr, outWrite, outLock, outSel, outEnable, outReady, outErr, inSel;
	logic inWrite, inLock, inReady, inResp, sysReqValid, sysWrite, sysLock, sysRspValid, sysErr;
	logic slow, failAll, identOn;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [19:0] outAddr;
	logic [31:0] wb_dat_i, wb_dat_o, reqAddr, reqWdata, rspRdata, outWdata, outRdata, rd;
	logic [31:0] inAddr, inWdata, inRdata, sysAddr, sysWdata, sysRdata;
	logic [1:0] reqSize, reqInit, outSize, outTrans, outIdent, inTrans, inSize, inMaster;
	logic [1:0] sysSize, sysMaster;
	int fails, total_checks, lat, pl;
	fabric_interface_bridge i_dut (.core_clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .reqValid, .reqAddr, .reqWrite,
		.reqWdata, .reqSize, .reqLock, .reqInit, .rspValid, .rspRdata, .rspErr, .outAddr,
		.outWdata, .outWrite, .outSize, .outTrans, .outLock, .outIdent, .outSel, .outEnable,
		.outRdata, .outReady, .outErr, .inSel, .inTrans, .inAddr, .inWrite, .inSize, .inLock,
		.inMaster, .inWdata, .inRdata, .inReady, .inResp, .sysReqValid, .sysAddr, .sysWrite,
		.sysWdata, .sysSize, .sysLock, .sysMaster, .sysRspValid, .sysRdata, .sysErr);
	fabric_slave_model i_slave (.core_clk, .arst_n, .outAddr, .outTrans, .outSel,
		.outEnable, .slow, .failAll, .tick(i_dut.tick), .outRdata, .outReady, .outErr);
	// Clock generator.
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic chk(input logic ok, input string m);
		total_checks++;
		if (!ok)
		begin
			fails++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// Bounded wait on a flag, sampled at the rising edge like the design.
	task automatic waitHi(input int k);
		for (lat = 1; lat <= 200; lat++)
		begin
			@(posedge core_clk);
			if ((({inReady, sysReqValid, rspValid, wb_ack_o} >> k) & 4'h1) === 4'h1)
				return;
		end
		fails++;
		wrap_up();
	endtask : waitHi
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		waitHi(0);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask : wb
	task automatic xfer(input logic [31:0] a, input logic [1:0] id, input logic e);
		@(posedge core_clk);
		{reqValid, reqAddr, reqWrite, reqWdata, reqInit} <= {1'b1, a, 1'b0, ~a, id};
		waitHi(1);
		chk(rspErr === e, "error flag");
		if (!e)
			chk(rspRdata === {12'ha5a, a[19:0]} && outWdata === ~a, "read data");
		reqValid <= 1'b0;
	endtask : xfer
	// Address-phase watcher: identity and address ride with the transfer type.
	always @(negedge core_clk)
		if (identOn && outTrans === fabric_bridge_pkg::TRANS_NONSEQ)
		begin
			chk(outIdent === reqInit, "identity");
			chk(outAddr === reqAddr[19:0] && outSize === reqSize, "address");
		end
	task t_regs;
		wb(1'b0, 4'h0, 32'h0);
		chk(rd[7:0] === fabric_bridge_pkg::CTRL_RESET, "ctrl reset");
		wb(1'b0, 4'h4, 32'h0);
		chk(rd[5:0] === fabric_bridge_pkg::REGION_RESET, "region reset");
		wb(1'b0, 4'h2, 32'h0);
		chk(rd === 32'h0, "unmapped");
	endtask : t_regs
	task t_out;
		wb(1'b1, 4'h0, 32'h16);
		identOn = 1'b1;
		for (int i = 0; i < 4; i++)
			xfer(32'h3001_2340 + 32'(i * 4), 2'(i), 1'b0);
		pl = lat;
		slow <= 1'b1;
		xfer(32'h5000_0088, 2'h2, 1'b0);
		chk(lat > pl, "wait states");
		{slow, failAll} <= 2'b01;
		xfer(32'h7000_0004, 2'h0, 1'b1);
		failAll <= 1'b0;
		xfer(32'h8000_0010, 2'h0, 1'b1);
		chk(rspRdata === 32'h0, "refused data");
	endtask : t_out
	task t_modes;
		wb(1'b1, 4'h0, 32'h1e);
		xfer(32'h3000_0100, 2'h3, 1'b0);
		chk(lat < pl, "bypass faster");
		wb(1'b1, 4'h0, 32'h1f);
		wb(1'b0, 4'h8, 32'h0);
		chk(rd[3] === 1'b0, "bypass with apb");
		xfer(32'h3000_0200, 2'h1, 1'b0);
		wb(1'b1, 4'h0, 32'h36);
		xfer(32'h3000_0300, 2'h0, 1'b0);
		chk(lat > pl, "ratio slower");
		wb(1'b1, 4'h0, 32'h14);
		xfer(32'h3000_0400, 2'h0, 1'b1);
		wb(1'b1, 4'h0, 32'h06);
	endtask : t_modes
	task t_in;
		@(posedge core_clk);
		{inSel, inTrans, inAddr, inMaster} <= {1'b1, 2'h2, 32'h2000_0010, 2'h3};
		@(posedge core_clk);
		{inSel, inTrans} <= 3'h0;
		waitHi(2);
		chk(sysAddr === 32'h2000_0010 && sysMaster === 2'h3, "inbound request");
		@(posedge core_clk);
		{sysRspValid, sysRdata} <= {1'b1, 32'h0bad_f00d};
		@(posedge core_clk);
		sysRspValid <= 1'b0;
		waitHi(3);
		chk(inRdata === 32'h0bad_f00d && inResp === 1'b0, "inbound answer");
		wb(1'b0, 4'hc, 32'h0);
		chk(rd[31:24] === 8'h01, "master count");
	endtask : t_in
	// Main sequence.
	initial
	begin
		{arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {40'h0, 4'hf};
		{reqValid, reqAddr, reqWrite, reqWdata, reqSize, reqLock, reqInit} = {66'h0, 2'h2, 3'h0};
		{inSel, inTrans, inAddr, inWrite, inSize, inLock, inMaster, inWdata} = 73'h0;
		{sysRspValid, sysRdata, sysErr, slow, failAll, identOn} = 37'h0;
		{fails, total_checks} = 64'h0;
		repeat (8) @(posedge core_clk);
		arst_n <= 1'b1;
		t_regs();
		t_out();
		t_modes();
		t_in();
		wrap_up();
	end
endmodule : fabric_interface_bridge_bench
